// ### hw/mbio_point_map.sv
// Contract
// (R1) FC1 reads coils, FC2 reads inputs.
// (R2) FC3 reads holding, FC4 reads input registers.
// (R3) FC5 writes one coil, revision two up.
// (R4) FC6 writes one holding register to output.
// (R5) FC15 writes several coils at once.
// (R6) Coils and inputs each own 112 points.
// (R7) Analog inputs own 112; analog outputs own 56.
// (R8) Sixteen addresses per module, base first.
// (R9) Function code picks area; offset picks module, point.
// (R10) Coil 00002 set drives second base output.
// (R11) Register 40049 drives module three analog output.
// (R12) Holding window: eight outputs, then counter words.
// (R13) Outputs latched in memory; inputs sampled into memory.
// (R14) Unimplemented address gives exception reply.
// (R15) Extended addresses are errors; offsets zero-based.
// (R16) Low count wraps at 9999, bumps high.
// (R17) Code 02 bad address, 01 bad function.
`timescale 1ns/1ps
`default_nettype none
module mbio_point_map #(
    parameter logic [6:0] FITTED_MASK = mbio_pkg::MBIO_DEF_FITTED,
    parameter logic [4:0] COIL_PTS    = mbio_pkg::MBIO_DEF_PTS,
    parameter logic [4:0] INPUT_PTS   = mbio_pkg::MBIO_DEF_PTS,
    parameter logic [4:0] INREG_PTS   = mbio_pkg::MBIO_DEF_PTS,
    parameter logic [7:0] FW_REV      = mbio_pkg::MBIO_FW_COIL_WR
) (
    input  wire logic           clk_sys_i,
    input  wire logic           rst_i,
    input  wire logic           req_valid_i,
    input  wire logic [7:0]     req_func_i,
    input  wire logic [15:0]    req_addr_i,
    input  wire logic [15:0]    req_qty_i,
    input  wire logic [15:0]    req_wdata_i,
    output logic                req_ready_o,
    output logic                rsp_valid_o,
    output logic                rsp_last_o,
    output logic                rsp_exc_o,
    output logic [7:0]          rsp_code_o,
    output logic [15:0]         rsp_data_o,
    input  wire logic [111:0]   sensed_input_bit_i,
    input  wire logic [1791:0]  analog_input_value_i,
    output logic [111:0]        coil_out_o,
    output logic                second_base_output_o,
    output logic [895:0]        analog_output_value_o
);

    typedef struct packed {
        mbio_pkg::mbio_fsm_t  fsm;
        logic [1:0]           area;
        logic [6:0]           idx;
        logic [4:0]           left;
        logic                 ready;
        logic                 rsp_valid;
        logic                 rsp_last;
        logic                 rsp_exc;
        logic [7:0]           rsp_code;
        logic [15:0]          rsp_data;
        logic [111:0]         s1;
        logic [111:0]         s2;
        logic [111:0]         s3;
        logic [111:0]         deb;
        logic [111:0]         coil;
        logic [111:0][15:0]   hold;
        logic [111:0][15:0]   anin;
    } mbio_st_t;

    mbio_st_t     st_r;
    mbio_st_t     st_nxt;
    logic [1:0]   acc_pulse;
    logic [1:0]   acc_wr_lo;
    logic [1:0]   acc_wr_hi;
    logic [15:0]  acc_lo [2];
    logic [15:0]  acc_hi [2];

    // ----------------------------------------------------------------------
    // Address map
    // ----------------------------------------------------------------------
    function automatic logic point_ok(input logic [1:0] area, input logic [6:0] idx);
        logic [2:0] m;
        logic [4:0] lim;
        m   = idx[6:4];                                        // R8
        case (area)
            mbio_pkg::MBIO_AREA_COIL:  lim = COIL_PTS;
            mbio_pkg::MBIO_AREA_INPUT: lim = INPUT_PTS;
            mbio_pkg::MBIO_AREA_INREG: lim = INREG_PTS;
            default: lim = mbio_pkg::MBIO_ANOUT_PER_MOD         // R12
                         + ((m == 3'h0) ? mbio_pkg::MBIO_BASE_CNT : mbio_pkg::MBIO_EXP_CNT);
        endcase
        return FITTED_MASK[m] && ({1'b0, idx[3:0]} < lim);
    endfunction

    // Every point of the span must exist; an extended address lands past 112.
    function automatic logic span_ok(input logic [1:0] area, input logic [15:0] addr,
                                     input logic [15:0] qty);
        logic        ok;
        logic [16:0] a;
        ok = 1'b1;
        for (int i = 0; i < 16; i++) begin
            a = {1'b0, addr} + 17'(i);
            if (17'(i) < {1'b0, qty}) begin
                if (a >= {1'b0, mbio_pkg::MBIO_AREA_PTS}) begin
                    ok = 1'b0;                                 // R6 R7 R15
                end else if (!point_ok(area, a[6:0])) begin
                    ok = 1'b0;                                 // R14
                end
            end
        end
        return ok;
    endfunction

    function automatic logic [15:0] word_at(input logic [1:0] area, input logic [6:0] idx);
        logic [15:0] w;
        w = st_r.hold[idx];
        if (area == mbio_pkg::MBIO_AREA_INREG) begin
            w = st_r.anin[idx];
        end else if (idx[6:4] == 3'h0) begin
            case (idx[3:0])
                mbio_pkg::MBIO_ACC0_HI_PT: w = acc_hi[0];
                mbio_pkg::MBIO_ACC0_LO_PT: w = acc_lo[0];
                mbio_pkg::MBIO_ACC1_HI_PT: w = acc_hi[1];
                mbio_pkg::MBIO_ACC1_LO_PT: w = acc_lo[1];
                default:                   w = st_r.hold[idx];
            endcase
        end
        return w;
    endfunction

    // ----------------------------------------------------------------------
    // Request handling
    // ----------------------------------------------------------------------
    always_comb begin
        logic [1:0]  area;
        logic [15:0] qty;
        logic        fok;
        logic [6:0]  ix;
        logic [6:0]  a7;
        area      = mbio_pkg::MBIO_AREA_COIL;
        qty       = req_qty_i;
        fok       = 1'b1;
        ix        = 7'h00;
        a7        = req_addr_i[6:0];
        acc_wr_lo = 2'b00;
        acc_wr_hi = 2'b00;
        st_nxt    = st_r;
        st_nxt.rsp_valid = 1'b0;
        st_nxt.rsp_last  = 1'b0;
        st_nxt.rsp_exc   = 1'b0;
        st_nxt.rsp_code  = 8'h00;
        st_nxt.rsp_data  = mbio_pkg::MBIO_RST_WORD;

        // Inputs settle into memory first; read replies are built only from memory.
        st_nxt.s1  = sensed_input_bit_i;                         // R13
        st_nxt.s2  = st_r.s1;
        st_nxt.s3  = st_r.s2;
        st_nxt.deb = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) | (st_r.deb & (st_r.s2 ^ st_r.s3));
        st_nxt.anin = analog_input_value_i;                      // R13
        acc_pulse  = st_nxt.deb[1:0] & ~st_r.deb[1:0];

        case (req_func_i)                                        // R9
            mbio_pkg::MBIO_FC_RD_COILS:  area = mbio_pkg::MBIO_AREA_COIL;
            mbio_pkg::MBIO_FC_RD_INPUTS: area = mbio_pkg::MBIO_AREA_INPUT;
            mbio_pkg::MBIO_FC_RD_HOLD:   area = mbio_pkg::MBIO_AREA_HOLD;
            mbio_pkg::MBIO_FC_RD_INREG:  area = mbio_pkg::MBIO_AREA_INREG;
            mbio_pkg::MBIO_FC_WR_COIL: begin
                qty = 16'h0001;
                fok = (FW_REV >= mbio_pkg::MBIO_FW_COIL_WR);     // R3
            end
            mbio_pkg::MBIO_FC_WR_REG: begin
                area = mbio_pkg::MBIO_AREA_HOLD;
                qty  = 16'h0001;
            end
            mbio_pkg::MBIO_FC_WR_COILS:  area = mbio_pkg::MBIO_AREA_COIL;
            default:                     fok = 1'b0;
        endcase

        case (st_r.fsm)
            mbio_pkg::MBIO_IDLE: begin
                if (req_valid_i && st_r.ready) begin
                    st_nxt.rsp_valid = 1'b1;
                    st_nxt.rsp_last  = 1'b1;
                    if (!fok) begin
                        st_nxt.rsp_exc  = 1'b1;                  // R17
                        st_nxt.rsp_code = mbio_pkg::MBIO_EXC_FUNC;
                    end else if (qty == 16'h0000 || qty > mbio_pkg::MBIO_MAX_QTY) begin
                        st_nxt.rsp_exc  = 1'b1;
                        st_nxt.rsp_code = mbio_pkg::MBIO_EXC_VALUE;
                    end else if (!span_ok(area, req_addr_i, qty)) begin
                        st_nxt.rsp_exc  = 1'b1;                  // R14 R17
                        st_nxt.rsp_code = mbio_pkg::MBIO_EXC_ADDR;
                    end else if (req_func_i == mbio_pkg::MBIO_FC_WR_COIL
                                 && req_wdata_i != mbio_pkg::MBIO_COIL_ON
                                 && req_wdata_i != mbio_pkg::MBIO_COIL_OFF) begin
                        st_nxt.rsp_exc  = 1'b1;
                        st_nxt.rsp_code = mbio_pkg::MBIO_EXC_VALUE;
                    end else begin
                        case (req_func_i)
                            mbio_pkg::MBIO_FC_RD_COILS,
                            mbio_pkg::MBIO_FC_RD_INPUTS: begin
                                for (int i = 0; i < 16; i++) begin
                                    ix = a7 + 7'(i);
                                    if (16'(i) < qty) begin      // R1
                                        st_nxt.rsp_data[i] = (area == mbio_pkg::MBIO_AREA_COIL)
                                                             ? st_r.coil[ix] : st_r.deb[ix];
                                    end
                                end
                            end
                            mbio_pkg::MBIO_FC_RD_HOLD,
                            mbio_pkg::MBIO_FC_RD_INREG: begin
                                st_nxt.rsp_data = word_at(area, a7); // R2
                                if (qty != 16'h0001) begin
                                    st_nxt.rsp_last = 1'b0;
                                    st_nxt.fsm      = mbio_pkg::MBIO_STREAM;
                                    st_nxt.area     = area;
                                    st_nxt.idx      = a7 + 7'h01;
                                    st_nxt.left     = 5'(qty - 16'h0001);
                                end
                            end
                            mbio_pkg::MBIO_FC_WR_COIL: begin
                                st_nxt.coil[a7] = (req_wdata_i == mbio_pkg::MBIO_COIL_ON); // R3 R10
                                st_nxt.rsp_data = req_wdata_i;
                            end
                            mbio_pkg::MBIO_FC_WR_REG: begin
                                st_nxt.rsp_data = req_wdata_i;
                                if (a7[6:4] == 3'h0 && a7[3:2] == 2'b10) begin
                                    acc_wr_hi[a7[1]] = ~a7[0];   // R16
                                    acc_wr_lo[a7[1]] = a7[0];
                                end else begin
                                    st_nxt.hold[a7] = req_wdata_i; // R4 R11 R13
                                end
                            end
                            default: begin
                                for (int i = 0; i < 16; i++) begin
                                    ix = a7 + 7'(i);
                                    if (16'(i) < qty) begin
                                        st_nxt.coil[ix] = req_wdata_i[i]; // R5
                                    end
                                end
                                st_nxt.rsp_data = qty;
                            end
                        endcase
                    end
                end
            end
            mbio_pkg::MBIO_STREAM: begin
                st_nxt.rsp_valid = 1'b1;
                st_nxt.rsp_data  = word_at(st_r.area, st_r.idx); // R2
                st_nxt.idx       = st_r.idx + 7'h01;
                st_nxt.left      = st_r.left - 5'h01;
                if (st_r.left == 5'h01) begin
                    st_nxt.rsp_last = 1'b1;
                    st_nxt.fsm      = mbio_pkg::MBIO_IDLE;
                end
            end
            default: st_nxt.fsm = mbio_pkg::MBIO_IDLE;
        endcase
        st_nxt.ready = (st_nxt.fsm == mbio_pkg::MBIO_IDLE);
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_r       <= '0;
            st_r.fsm   <= mbio_pkg::MBIO_IDLE;
            st_r.ready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------------
    // Base module counters
    // ----------------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_acc
        mbio_accum u_acc (
            .clk_sys_i (clk_sys_i),
            .rst_i     (rst_i),
            .pulse_i   (acc_pulse[g]),
            .wr_lo_i   (acc_wr_lo[g]),
            .wr_hi_i   (acc_wr_hi[g]),
            .wdata_i   (req_wdata_i),
            .lo_o      (acc_lo[g]),
            .hi_o      (acc_hi[g])
        );
    end

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------
    // Physical outputs follow the latched memory, never the request directly.
    for (genvar m = 0; m < mbio_pkg::MBIO_NUM_MOD; m++) begin : g_mod
        for (genvar p = 0; p < mbio_pkg::MBIO_ANOUT_SLOTS; p++) begin : g_pt
            assign analog_output_value_o[(m * 8 + p) * 16 +: 16] =
                st_r.hold[m * mbio_pkg::MBIO_WIN + p];           // R4 R13
        end
    end

    assign coil_out_o           = st_r.coil;                     // R13
    assign second_base_output_o = st_r.coil[1];                  // R10
    assign req_ready_o          = st_r.ready;
    assign rsp_valid_o          = st_r.rsp_valid;
    assign rsp_last_o           = st_r.rsp_last;
    assign rsp_exc_o            = st_r.rsp_exc;
    assign rsp_code_o           = st_r.rsp_code;
    assign rsp_data_o           = st_r.rsp_data;

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    chk_bad_func_code: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R17
        (req_valid_i && req_ready_o && req_func_i == 8'h07)
        |=> (rsp_valid_o && rsp_exc_o && rsp_code_o == 8'h01))
        else $error("Unsupported function did not give illegal function.");

    chk_extended_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R15
        (req_valid_i && req_ready_o && req_func_i == 8'h03 && req_addr_i >= 16'h0070
         && req_qty_i == 16'h0001)
        |=> (rsp_exc_o && rsp_code_o == 8'h02))
        else $error("Out of map address did not give illegal address.");

    chk_coil_two_on: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R10
        (req_valid_i && req_ready_o && req_func_i == 8'h05 && req_addr_i == 16'h0001
         && req_wdata_i == 16'hFF00 && FITTED_MASK[0] && FW_REV >= 8'h02)
        |=> (second_base_output_o && coil_out_o[1] && !rsp_exc_o))
        else $error("Second base output not driven after coil write.");

    chk_ao_mod_three: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R11
        (req_valid_i && req_ready_o && req_func_i == 8'h06 && req_addr_i == 16'h0030
         && FITTED_MASK[3])
        |=> (analog_output_value_o[24 * 16 +: 16] == $past(req_wdata_i)))
        else $error("Module three first analog output not updated.");

    chk_multi_coil: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R5
        (req_valid_i && req_ready_o && req_func_i == 8'h0F && req_addr_i == 16'h0000
         && req_qty_i == 16'h0004 && FITTED_MASK[0] && COIL_PTS >= 5'h04)
        |=> (coil_out_o[3:0] == $past(req_wdata_i[3:0]) && rsp_last_o))
        else $error("Multiple coil write not applied.");

    chk_input_read: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R1
        (req_valid_i && req_ready_o && req_func_i == 8'h02 && req_addr_i == 16'h0000
         && req_qty_i == 16'h0001 && FITTED_MASK[0])
        |=> (rsp_valid_o && !rsp_exc_o && rsp_data_o[0] == $past(st_r.deb[0])))
        else $error("Input read did not return the stored input state.");

    chk_reg_stream: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R2
        (req_valid_i && req_ready_o && req_func_i == 8'h04 && req_addr_i == 16'h0000
         && req_qty_i == 16'h0003 && FITTED_MASK[0] && INREG_PTS >= 5'h03)
        |=> (rsp_valid_o && !rsp_last_o && !req_ready_o)[*2]
            ##1 (rsp_valid_o && rsp_last_o) ##1 req_ready_o)
        else $error("Register read did not stream three words.");

    chk_hold_window: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R12
        (req_valid_i && req_ready_o && req_func_i == 8'h03 && req_addr_i == 16'h001A
         && req_qty_i == 16'h0001)
        |=> (rsp_exc_o && rsp_code_o == 8'h02))
        else $error("Unmapped expansion counter slot was accepted.");

endmodule // mbio_point_map
`default_nettype wire

// ### hw/mbio_pkg.sv
package mbio_pkg;

    // ----------------------------------------------------------------------
    // Map geometry
    // ----------------------------------------------------------------------
    localparam int unsigned  MBIO_NUM_MOD    = 7;
    localparam int unsigned  MBIO_WIN        = 16;
    localparam int unsigned  MBIO_ANOUT_SLOTS = 8;
    localparam logic [15:0]  MBIO_AREA_PTS   = 16'h0070;
    localparam logic [15:0]  MBIO_MAX_QTY    = 16'h0010;
    localparam logic [4:0]   MBIO_ANOUT_PER_MOD = 5'h08;
    localparam logic [4:0]   MBIO_BASE_CNT   = 5'h07;
    localparam logic [4:0]   MBIO_EXP_CNT    = 5'h02;
    localparam logic [4:0]   MBIO_DEF_PTS    = 5'h10;
    localparam logic [6:0]   MBIO_DEF_FITTED = 7'h7F;

    // ----------------------------------------------------------------------
    // Point type areas
    // ----------------------------------------------------------------------
    localparam logic [1:0]   MBIO_AREA_COIL  = 2'h0;
    localparam logic [1:0]   MBIO_AREA_INPUT = 2'h1;
    localparam logic [1:0]   MBIO_AREA_INREG = 2'h2;
    localparam logic [1:0]   MBIO_AREA_HOLD  = 2'h3;

    // ----------------------------------------------------------------------
    // Function and exception codes
    // ----------------------------------------------------------------------
    localparam logic [7:0]   MBIO_FC_RD_COILS  = 8'h01;
    localparam logic [7:0]   MBIO_FC_RD_INPUTS = 8'h02;
    localparam logic [7:0]   MBIO_FC_RD_HOLD   = 8'h03;
    localparam logic [7:0]   MBIO_FC_RD_INREG  = 8'h04;
    localparam logic [7:0]   MBIO_FC_WR_COIL   = 8'h05;
    localparam logic [7:0]   MBIO_FC_WR_REG    = 8'h06;
    localparam logic [7:0]   MBIO_FC_WR_COILS  = 8'h0F;
    localparam logic [7:0]   MBIO_EXC_FUNC     = 8'h01;
    localparam logic [7:0]   MBIO_EXC_ADDR     = 8'h02;
    localparam logic [7:0]   MBIO_EXC_VALUE    = 8'h03;
    localparam logic [7:0]   MBIO_FW_COIL_WR   = 8'h02;
    localparam logic [15:0]  MBIO_COIL_ON      = 16'hFF00;
    localparam logic [15:0]  MBIO_COIL_OFF     = 16'h0000;

    // ----------------------------------------------------------------------
    // Counters in the base holding window
    // ----------------------------------------------------------------------
    localparam logic [13:0]  MBIO_ACC_MAX    = 14'h270F;
    localparam logic [3:0]   MBIO_ACC0_HI_PT = 4'h8;
    localparam logic [3:0]   MBIO_ACC0_LO_PT = 4'h9;
    localparam logic [3:0]   MBIO_ACC1_HI_PT = 4'hA;
    localparam logic [3:0]   MBIO_ACC1_LO_PT = 4'hB;
    localparam logic [15:0]  MBIO_RST_WORD   = 16'h0000;

    typedef enum logic [0:0] {
        MBIO_IDLE,
        MBIO_STREAM
    } mbio_fsm_t;

endpackage

// ### hw/mbio_accum.sv
`timescale 1ns/1ps
`default_nettype none
module mbio_accum (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        pulse_i,
    input  wire logic        wr_lo_i,
    input  wire logic        wr_hi_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] lo_o,
    output logic      [15:0] hi_o
);

    typedef struct packed {
        logic [13:0] lo;
        logic [13:0] hi;
    } mbio_acc_st_t;

    mbio_acc_st_t st_r;
    mbio_acc_st_t st_nxt;

    // A pulse in the same cycle as a write counts on top of the written value.
    always_comb begin
        st_nxt = st_r;
        if (wr_lo_i) begin
            st_nxt.lo = wdata_i[13:0];
        end
        if (wr_hi_i) begin
            st_nxt.hi = wdata_i[13:0];
        end
        if (pulse_i) begin
            if (st_nxt.lo >= mbio_pkg::MBIO_ACC_MAX) begin
                st_nxt.lo = 14'h0000; // R16
                st_nxt.hi = (st_nxt.hi >= mbio_pkg::MBIO_ACC_MAX) ? 14'h0000
                                                                   : st_nxt.hi + 14'h0001;
            end else begin
                st_nxt.lo = st_nxt.lo + 14'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lo_o = {2'b00, st_r.lo};
    assign hi_o = {2'b00, st_r.hi};

    chk_acc_wrap: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R16
        (pulse_i && !wr_lo_i && !wr_hi_i && st_r.lo == mbio_pkg::MBIO_ACC_MAX
         && st_r.hi < mbio_pkg::MBIO_ACC_MAX)
        |=> (st_r.lo == 14'h0000 && st_r.hi == $past(st_r.hi) + 14'h0001))
        else $error("Accumulator low count did not wrap into the high count.");

endmodule // mbio_accum
`default_nettype wire

// ### testbench/mbio_master.sv
`timescale 1ns/1ps
`default_nettype none
module mbio_master (
    input  wire logic        clk_sys_i,
    input  wire logic        req_ready_i,
    output logic             req_valid_o,
    output logic [7:0]       req_func_o,
    output logic [15:0]      req_addr_o,
    output logic [15:0]      req_qty_o,
    output logic [15:0]      req_wdata_o
);
    // ----------------------------------------------------------------------
    // Request driver
    // ----------------------------------------------------------------------
    // Released fields carry inverted data so that a stale sample cannot match.
    task automatic send(input logic [7:0] f, input logic [15:0] a, q, d);
        int n;
        @(posedge clk_sys_i);
        #1;
        {req_func_o, req_addr_o, req_qty_o, req_wdata_o} = {f, a, q, d};
        req_valid_o = 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (req_ready_i !== 1'b1 && n < 40);
        #1;
        req_valid_o = 1'b0;
        {req_func_o, req_addr_o, req_qty_o, req_wdata_o} = ~{f, a, q, d};
    endtask

    initial begin
        {req_valid_o, req_func_o, req_addr_o, req_qty_o, req_wdata_o} = '0;
    end
endmodule // mbio_master
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic           clk_sys_i, rst_i, req_valid, req_ready, rsp_valid, rsp_last, rsp_exc;
    logic           second_out;
    logic [7:0]     req_func, rsp_code, cd;
    logic [15:0]    req_addr, req_qty, req_wdata, rsp_data, ex;
    logic [15:0]    w [0:19];
    logic [111:0]   sib, coil_out;
    logic [1791:0]  ain;
    logic [895:0]   aout;
    int             fail_count = 0, checked = 0, nw, cycles = 0;

    mbio_master mbio_master_i (.clk_sys_i(clk_sys_i), .req_ready_i(req_ready),
        .req_valid_o(req_valid), .req_func_o(req_func), .req_addr_o(req_addr),
        .req_qty_o(req_qty), .req_wdata_o(req_wdata));
    mbio_point_map mbio_point_map_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .req_valid_i(req_valid), .req_func_i(req_func), .req_addr_i(req_addr),
        .req_qty_i(req_qty), .req_wdata_i(req_wdata), .req_ready_o(req_ready),
        .rsp_valid_o(rsp_valid), .rsp_last_o(rsp_last), .rsp_exc_o(rsp_exc),
        .rsp_code_o(rsp_code), .rsp_data_o(rsp_data), .sensed_input_bit_i(sib),
        .analog_input_value_i(ain), .coil_out_o(coil_out),
        .second_base_output_o(second_out), .analog_output_value_o(aout));

    // ----------------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------------
    task automatic print_verdict();
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Replies are sampled on the falling edge, where registered outputs are settled.
    task automatic rq(input logic [7:0] f, input logic [15:0] a, q, d);
        mbio_master_i.send(f, a, q, d);
        nw = 0;
        {w[0], ex, cd} = 'x;
        for (int n = 0; n < 20 && nw < 20; n++) begin
            @(negedge clk_sys_i);
            if (rsp_valid === 1'b1) begin
                w[nw] = rsp_data;
                ex = {15'h0000, rsp_exc};
                cd = rsp_code;
                nw++;
                if (rsp_last === 1'b1) break;
            end
        end
    endtask
    task automatic err(input logic [7:0] f, input logic [15:0] a, q, d, input logic [7:0] c);
        rq(f, a, q, d);
        chk(ex, 16'h0001);
        chk({8'h00, cd}, {8'h00, c});
    endtask

    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    task automatic s_coils();
        rq(8'h05, 16'h0001, 16'h0000, 16'hFF00);
        chk(w[0], 16'hFF00);
        chk({15'h0000, second_out}, 16'h0001);
        rq(8'h0F, 16'h0010, 16'h0003, 16'h0005);
        chk(coil_out[31:16], 16'h0005);
        rq(8'h01, 16'h0000, 16'h0004, 16'h0000);
        chk(w[0], 16'h0002);
        rq(8'h0F, 16'h0000, 16'h0004, 16'h000A);
        chk(coil_out[15:0], 16'h000A);
    endtask
    task automatic s_hold();
        rq(8'h06, 16'h0030, 16'h0000, 16'h1234);
        chk(w[0], 16'h1234);
        chk(aout[399:384], 16'h1234);
        rq(8'h03, 16'h0030, 16'h0002, 16'h0000);
        chk(16'(nw), 16'h0002);
        chk(w[0], 16'h1234);
        chk(w[1], 16'h0000);
    endtask
    task automatic s_inputs();
        @(posedge clk_sys_i);
        #1;
        sib[97] = 1'b1;
        ain[1791:1776] = 16'hBEEF;
        repeat (6) @(posedge clk_sys_i);
        rq(8'h02, 16'h0060, 16'h0002, 16'h0000);
        chk(w[0], 16'h0002);
        rq(8'h04, 16'h006F, 16'h0001, 16'h0000);
        chk(w[0], 16'hBEEF);
        rq(8'h01, 16'h0060, 16'h0002, 16'h0000);
        chk(w[0], 16'h0000);
        rq(8'h02, 16'h0000, 16'h0001, 16'h0000);
        chk(w[0], 16'h0000);
        rq(8'h04, 16'h0000, 16'h0003, 16'h0000);
        chk(16'(nw), 16'h0003);
    endtask
    task automatic s_accum();
        rq(8'h06, 16'h0009, 16'h0000, 16'h270F);
        @(posedge clk_sys_i);
        #1;
        sib[0] = 1'b1;
        repeat (8) @(posedge clk_sys_i);
        rq(8'h03, 16'h0008, 16'h0002, 16'h0000);
        chk(w[0], 16'h0001);
        chk(w[1], 16'h0000);
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        rst_i = 1'b1;
        sib = '0;
        ain = '0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chk({15'h0000, req_ready}, 16'h0001);
        s_coils();
        s_hold();
        s_inputs();
        s_accum();
        err(8'h07, 16'h0000, 16'h0001, 16'h0000, 8'h01);
        err(8'h03, 16'h0070, 16'h0001, 16'h0000, 8'h02);
        err(8'h01, 16'h006E, 16'h0003, 16'h0000, 8'h02);
        err(8'h03, 16'h9C4C, 16'h0001, 16'h0000, 8'h02);
        err(8'h03, 16'h000F, 16'h0001, 16'h0000, 8'h02);
        err(8'h03, 16'h001A, 16'h0001, 16'h0000, 8'h02);
        err(8'h01, 16'h0000, 16'h0000, 16'h0000, 8'h03);
        err(8'h05, 16'h0001, 16'h0000, 16'h1234, 8'h03);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
